// ### design/sar_readout.v
/*
 conversion start and serial readout of a 16-bit successive
 approximation converter: select mode (3/4 wire, busy optional) and
 chain mode. assumes a 10 MHz clock and that the host drives start,
 select and serial clock asynchronously; the sample value arrives on
 a parallel port already quantised or flagged over/under range.
*/
`timescale 1ns/1ps
`include "sar_regs.vh"
module sar_readout #(
   parameter TCONV_NS = `SAR_TCONV_MAX_NS
) (
   // clock and reset
   input wire MCLK,
   input wire RESET_N,
   // analog front end result
   input wire [15:0] SAMPLE_CODE,
   input wire SAMPLE_OVER,
   input wire SAMPLE_UNDER,
   // host pins
   input wire CONVERT_START,
   input wire SELECT_IN,
   input wire SCK,
   output reg SERIAL_OUT_O,
   output reg SERIAL_OUT_OE,
   // status
   output reg CONVERTING,
   output reg POWERED_DOWN
);
   // =====================================================
   // timing: end time clamped into [min,max] window, rounded down
   localparam integer T_END = (TCONV_NS < `SAR_TCONV_MIN_NS) ? `SAR_TCONV_MIN_NS :
      (TCONV_NS > `SAR_TCONV_MAX_NS) ? `SAR_TCONV_MAX_NS : TCONV_NS;
   localparam integer END_CYC_I = (T_END / `SAR_CLK_NS) < 1 ? 1 : T_END / `SAR_CLK_NS;
   localparam [`SAR_CNT_W-1:0] END_CYC = END_CYC_I[`SAR_CNT_W-1:0];

   // states
   localparam [1:0] ST_ACQ = 2'h0;
   localparam [1:0] ST_CONV = 2'h1;
   localparam [1:0] ST_READ = 2'h2;

   function [15:0] sar_quant;
      input [15:0] code;
      input over;
      input under;
      begin
         if (over)
            sar_quant = `SAR_CODE_FULL;
         else if (under)
            sar_quant = `SAR_CODE_ZERO;
         else
            sar_quant = code;
      end
   endfunction

   // =====================================================
   // pin synchronisers
   wire cnv_s;
   wire sel_s;
   wire sck_s;
   sar_sync u_cnv (.clk(MCLK), .rst_n(RESET_N), .d(CONVERT_START), .q(cnv_s));
   sar_sync u_sel (.clk(MCLK), .rst_n(RESET_N), .d(SELECT_IN), .q(sel_s));
   sar_sync u_sck (.clk(MCLK), .rst_n(RESET_N), .d(SCK), .q(sck_s));

   reg cnv_d_reg;
   reg sel_d_reg;
   reg sck_d_reg;
   wire cnv_rise = cnv_s & ~cnv_d_reg;
   wire cnv_fall = ~cnv_s & cnv_d_reg;
   wire sel_rise = sel_s & ~sel_d_reg;
   wire sel_fall = ~sel_s & sel_d_reg;
   wire sck_fall = ~sck_s & sck_d_reg;

   // =====================================================
   // state
   reg [1:0] state_reg;
   reg [`SAR_CNT_W-1:0] cnt_reg;
   reg chain_reg;
   reg busy_reg;
   reg [16:0] shift_reg;
   reg [4:0] bits_reg;
   reg drive_reg;
   reg shift_en_reg;

   wire conv_done = (state_reg == ST_CONV) && (cnt_reg == END_CYC - 8'h01);
   wire [15:0] result = sar_quant(SAMPLE_CODE, SAMPLE_OVER, SAMPLE_UNDER);
   wire busy_sel_now = ~cnv_s | ~sel_s;

   always @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnv_d_reg <= 1'b0;
         sel_d_reg <= 1'b0;
         sck_d_reg <= 1'b0;
         state_reg <= ST_ACQ;
         cnt_reg <= {`SAR_CNT_W{1'b0}};
         chain_reg <= 1'b0;
         busy_reg <= 1'b0;
         shift_reg <= 17'h00000;
         bits_reg <= 5'h00;
         drive_reg <= 1'b0;
         shift_en_reg <= 1'b0;
         SERIAL_OUT_O <= 1'b0;
         SERIAL_OUT_OE <= 1'b0;
         CONVERTING <= 1'b0;
         POWERED_DOWN <= 1'b1;
      end else begin
         cnv_d_reg <= cnv_s;
         sel_d_reg <= sel_s;
         sck_d_reg <= sck_s;
         case (state_reg)
            ST_CONV: begin
               // internal count only, serial clock ignored; start edges ignored
               cnt_reg <= cnt_reg + 8'h01;
               if (conv_done) begin
                  state_reg <= ST_READ;
                  CONVERTING <= 1'b0;
                  POWERED_DOWN <= 1'b1;
                  if (chain_reg) begin
                     // chain: MSB or busy high lands on output at once
                     shift_reg <= busy_reg ? {1'b1, result} : {result, 1'b0};
                     bits_reg <= busy_reg ? `SAR_BITS_BUSY : `SAR_BITS_PLAIN;
                     drive_reg <= 1'b1;
                     shift_en_reg <= 1'b1;
                  end else if (busy_sel_now) begin
                     // busy start bit driven low, data follows
                     busy_reg <= 1'b1;
                     shift_reg <= {1'b0, result};
                     bits_reg <= `SAR_BITS_BUSY;
                     drive_reg <= 1'b1;
                     shift_en_reg <= 1'b1;
                  end else begin
                     busy_reg <= 1'b0;
                     shift_reg <= {result, 1'b0};
                     bits_reg <= `SAR_BITS_PLAIN;
                     drive_reg <= 1'b0;
                     shift_en_reg <= 1'b0;
                  end
               end
            end
            ST_READ: begin
               if (cnv_rise) begin
                  // new conversion; chain or select decided below
                  state_reg <= ST_CONV;
               end else if (!chain_reg && !busy_reg && !shift_en_reg) begin
                  // waiting for the select window; one readout per conversion only
                  if ((cnv_fall || sel_fall) && bits_reg != 5'h00) begin
                     drive_reg <= 1'b1;
                     shift_en_reg <= 1'b1;
                  end
               end else if (!chain_reg && sel_rise) begin
                  drive_reg <= 1'b0;
                  shift_en_reg <= 1'b0;
                  bits_reg <= 5'h00;
               end else if (shift_en_reg && sck_fall) begin
                  // bit changes only on falling clock, stable across rise
                  shift_reg <= {shift_reg[15:0], chain_reg ? sel_s : 1'b0};
                  bits_reg <= bits_reg - 5'h01;
                  if (bits_reg == 5'h01 && !chain_reg) begin
                     drive_reg <= 1'b0;
                     shift_en_reg <= 1'b0;
                  end
               end
            end
            default: begin
               state_reg <= ST_ACQ;
            end
         endcase
         // conversion start from acquisition or after readback
         if (cnv_rise && state_reg != ST_CONV) begin
            state_reg <= ST_CONV;
            cnt_reg <= {`SAR_CNT_W{1'b0}};
            CONVERTING <= 1'b1;
            POWERED_DOWN <= 1'b0;
            // previous sampled select decides; a tied select is still low here
            chain_reg <= ~sel_d_reg;
            busy_reg <= sel_d_reg ? 1'b0 : sck_s;
            drive_reg <= 1'b0;
            shift_en_reg <= 1'b0;
         end
         // output pin, registered
         if (state_reg == ST_READ && drive_reg) begin
            SERIAL_OUT_OE <= 1'b1;
            SERIAL_OUT_O <= busy_reg && !chain_reg ? shift_reg[16] : shift_reg[16];
         end else if (!cnv_s && !sel_s) begin
            SERIAL_OUT_OE <= 1'b1;
            SERIAL_OUT_O <= 1'b0;
         end else begin
            SERIAL_OUT_OE <= 1'b0;
            SERIAL_OUT_O <= 1'b0;
         end
      end
   end
endmodule // sar_readout

// ### design/sar_regs.vh
/*
 constants for the serial readout of the 16-bit sampling converter:
 result width, code points, conversion window and tick counts.
 assumes a 10 MHz system clock.
*/
`ifndef SAR_REGS_VH
`define SAR_REGS_VH
// =====================================================
// result format
`define SAR_RES_W 16
`define SAR_CODE_ZERO 16'h0000
`define SAR_CODE_MID 16'h8000
`define SAR_CODE_FULL 16'hFFFF
`define SAR_BITS_PLAIN 5'h10
`define SAR_BITS_BUSY 5'h11
// =====================================================
// conversion window in ns, clock period in ns
`define SAR_CLK_NS 100
`define SAR_TCONV_MIN_NS 500
`define SAR_TCONV_MAX_NS 710
`define SAR_CNT_W 8
`endif

// ### design/sar_sync.v
/*
 two-flop synchroniser for one level from outside the clock domain.
 assumes clk is the system clock; output has two cycles of latency.
*/
`timescale 1ns/1ps
module sar_sync (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // level
   input wire d,
   output reg q
);
   reg meta_reg;
   // first flop is read only by the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sar_sync

// ### test/sar_host.sv
/*
 host model: drives start, select and serial clock, samples data.
 assumes its tasks are entered at a falling MCLK edge.
*/
`timescale 1ns/1ps
module sar_host (
   // clock
   input wire clk,
   // device pins
   output reg convert_start,
   output reg select_in,
   output reg sck,
   input wire so,
   input wire oe
);
   initial begin
      convert_start = 1'b0;
      select_in = 1'b1;
      sck = 1'b0;
   end
   // ==========================================
   // pin tasks, single device so no contention on the data line
   task pins(input s, input c, input integer n);
      begin
         select_in = s;
         convert_start = c;
         repeat (n) @(negedge clk);
      end
   endtask
   // sample at the end of the high phase, far from the shift after each fall
   task read(input integer n, output [16:0] w);
      integer i;
      begin
         w = 17'h00000;
         for (i = 0; i < n; i = i + 1) begin
            sck = 1'b1;
            repeat (4) @(negedge clk);
            w = {w[15:0], oe ? so : 1'bx};
            sck = 1'b0;
            repeat (4) @(negedge clk);
         end
      end
   endtask
endmodule // sar_host

// ### test/sar_monitor.sv
/*
 checker on the ports of sar_readout.
 assumes a 10 MHz MCLK; bound from the testbench file.
*/
`timescale 1ns/1ps
module sar_monitor (
   // clock and reset
   input wire MCLK,
   input wire RESET_N,
   // pins and status
   input wire CONVERT_START,
   input wire SELECT_IN,
   input wire SCK,
   input wire SERIAL_OUT_O,
   input wire SERIAL_OUT_OE,
   input wire CONVERTING,
   input wire POWERED_DOWN
);
   // ==========================================
   // properties
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   property p_win; $rose(CONVERTING) |-> CONVERTING[*5] ##[1:4] !CONVERTING; endproperty
   a_win: assert property (p_win) else $error("conversion length outside window");
   property p_quiet; $rose(CONVERTING) |=> (!SERIAL_OUT_OE)[*5]; endproperty
   a_quiet: assert property (p_quiet) else $error("output driven in conversion");
   property p_pd; $fell(CONVERTING) |-> ##[0:2] POWERED_DOWN; endproperty
   a_pd: assert property (p_pd) else $error("no power down after conversion");
   property p_excl; CONVERTING |-> !POWERED_DOWN; endproperty
   a_excl: assert property (p_excl) else $error("powered down while converting");
   property p_busy;
      $fell(CONVERTING) && !CONVERT_START && !$past(CONVERT_START, 5)
         |-> ##[0:2] (SERIAL_OUT_OE && !SERIAL_OUT_O);
   endproperty
   a_busy: assert property (p_busy) else $error("start bit missing");
   property p_hold;
      SERIAL_OUT_OE && $past(SERIAL_OUT_OE) && SCK && $past(SCK, 3) |-> $stable(SERIAL_OUT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("bit moved while clock high");
   property p_low;
      (!CONVERT_START && !SELECT_IN && !CONVERTING)[*6] |-> SERIAL_OUT_OE && !SERIAL_OUT_O;
   endproperty
   a_low: assert property (p_low) else $error("output not driven low");
   property p_msb;
      !CONVERTING && SELECT_IN && $fell(CONVERT_START) |-> ##[2:6] SERIAL_OUT_OE;
   endproperty
   a_msb: assert property (p_msb) else $error("msb not driven after start fall");
   c_busy: cover property ($fell(CONVERTING) && !CONVERT_START);
   c_plain: cover property ($fell(CONVERTING) && CONVERT_START);
   c_off: cover property ($fell(SERIAL_OUT_OE) && !SCK);
endmodule // sar_monitor

// ### test/testbench.sv
/*
 top bench: sar_readout, host model, queue model of results.
 assumes 100 ns MCLK and an 800 ns serial clock.
*/
`timescale 1ns/1ps
module testbench;
   reg mclk;
   reg reset_n;
   reg [15:0] code;
   reg over;
   reg under;
   reg [16:0] got;
   wire cs, sel, sck, so, oe, conv, pd;
   integer miscompares = 0;
   integer num_checks = 0;
   integer i, n, e;
   integer exp_q[$];
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   sar_readout sar_readout_inst (.MCLK(mclk), .RESET_N(reset_n), .SAMPLE_CODE(code),
      .SAMPLE_OVER(over), .SAMPLE_UNDER(under), .CONVERT_START(cs), .SELECT_IN(sel),
      .SCK(sck), .SERIAL_OUT_O(so), .SERIAL_OUT_OE(oe), .CONVERTING(conv),
      .POWERED_DOWN(pd));
   sar_host sar_host_inst (.clk(mclk), .convert_start(cs), .select_in(sel), .sck(sck),
      .so(so), .oe(oe));
   task finish_test;
      begin
         if (miscompares == 0 && num_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task cmp(input [8*4:1] name, input [16:0] x, input [16:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("mismatch %0s expected %h seen %h", name, x, g);
         end
      end
   endtask
   task wait_cv(input v);
      integer k;
      begin
         for (k = 0; k < 40 && conv !== v; k = k + 1) @(negedge mclk);
         if (conv !== v) begin
            miscompares = miscompares + 1;
            finish_test;
         end
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      reset_n = 1'b0;
      code = 16'h0000;
      over = 1'b0;
      under = 1'b0;
      i = $urandom(32'hADBAB7B7);
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      for (i = 0; i < 6; i = i + 1) begin
         code = $urandom;
         over = (i == 2);
         under = (i == 3);
         exp_q.push_back(over ? 32'hFFFF : under ? 0 : code);
         sar_host_inst.pins(1'b1, 1'b1, 1);
         wait_cv(1'b1);
         sar_host_inst.pins(1'b1, 1'b0, 1);
         sar_host_inst.pins(1'b1, !i[0], 1);
         wait_cv(1'b0);
         sar_host_inst.pins(1'b1, 1'b0, 6);
         cmp("pd", 17'h1, {16'h0, pd});
         cmp("oe", 17'h1, {16'h0, oe});
         n = (i > 3) ? 8 : 16 + i % 2;
         sar_host_inst.read(n, got);
         e = exp_q.pop_front();
         cmp("word", 17'(e >> (16 + i % 2 - n)), got);
         sar_host_inst.pins(1'b1, i > 3, 6);
         cmp("off", 17'h0, {16'h0, oe});
         if (i > 3) begin
            wait_cv(1'b0);
            sar_host_inst.pins(1'b1, 1'b0, 8);
            sar_host_inst.read(16, got);
            cmp("word", {1'b0, code}, got);
         end
      end
      // 4-wire select: start held high, select pulsed early then used to read
      code = $urandom;
      sar_host_inst.pins(1'b1, 1'b1, 1);
      wait_cv(1'b1);
      sar_host_inst.pins(1'b0, 1'b1, 1);
      sar_host_inst.pins(1'b1, 1'b1, 1);
      wait_cv(1'b0);
      sar_host_inst.pins(1'b0, 1'b1, 6);
      sar_host_inst.read(16, got);
      cmp("word", {1'b0, code}, got);
      sar_host_inst.pins(1'b1, 1'b1, 6);
      cmp("off", 17'h0, {16'h0, oe});
      sar_host_inst.pins(1'b0, 1'b0, 8);
      cmp("low", 17'h2, {15'h0, oe, so});
      sar_host_inst.pins(1'b1, 1'b0, 2);
      finish_test;
   end
endmodule // testbench
bind sar_readout sar_monitor sar_monitor_inst (.MCLK(MCLK), .RESET_N(RESET_N),
   .CONVERT_START(CONVERT_START), .SELECT_IN(SELECT_IN), .SCK(SCK),
   .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE(SERIAL_OUT_OE), .CONVERTING(CONVERTING),
   .POWERED_DOWN(POWERED_DOWN));
